// ### common/ars_pkg.sv
// Shared constants and types for the automatic range selector
package ars_pkg;

   // Clock and settling delay
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned MS_PER_S = 1_000;
   localparam int unsigned SETTLE_MS = 100;
   // Divide first so the product stays well inside 32 bits
   localparam int unsigned SETTLE_CYC = (CLK_HZ / MS_PER_S) * SETTLE_MS;
   localparam int unsigned CNT_W = 21;

   // Decade limits of the stored count
   localparam logic [3:0] DIGIT_ZERO = 4'h0;
   localparam logic [3:0] UP_HUND = 4'h4;

   // APB register byte addresses
   localparam int unsigned ADDR_W = 12;
   localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] REG_IRQ_STS = 12'h008;
   localparam logic [ADDR_W-1:0] REG_IRQ_MSK = 12'h00C;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // Control register fields and reset values
   localparam int unsigned CTRL_AC_BIT = 0;
   localparam logic CTRL_AC_RST = 1'b0;

   // Stored count from the counter memory, BCD
   typedef struct packed {
      logic thou;
      logic [3:0] hund;
      logic [3:0] tens;
      logic [3:0] units;
   } ars_count_s;

   // Range state: bit 0 is the low state bit, bit 1 the high state bit
   typedef enum logic [1:0] {
      RNG_10,
      RNG_100,
      RNG_1000,
      RNG_OVL
   } ars_range_e;

   typedef struct packed {
      logic relay_a;
      logic relay_b;
      logic relay_c;
      logic overload;
   } ars_drive_s;

   typedef struct packed {
      logic ovl;
      logic down;
      logic up;
   } ars_irq_s;

   localparam ars_irq_s IRQ_RST = 3'h0;

   typedef struct packed {
      logic [25:0] rsvd;
      logic settling;
      logic xfer;
      logic up_flag;
      logic lo_flag;
      ars_range_e range;
   } ars_status_s;

   typedef struct packed {
      logic [ADDR_W-1:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } ars_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ars_apb_rsp_s;

   typedef struct packed {
      ars_range_e rng;
      logic xfer_prev;
      logic ac_mode;
      ars_irq_s irq_sts;
      ars_irq_s irq_msk;
      logic [CNT_W-1:0] settle_cnt;
      logic rd_valid;
      logic [31:0] prdata;
   } ars_state_s;

endpackage : ars_pkg

// ### rtl/ars_limits.sv
// Threshold flags decoded from the stored BCD count
`timescale 1ns/1ns
module ars_limits
   import ars_pkg::*;
(
   input wire ars_count_s count_i,
   output logic lo_flag_o,
   output logic up_flag_o
);

   logic hund_zero;
   logic below_rest;

   // Flags are pure gating so they settle long before the transfer edge
   always_comb begin
      hund_zero = (count_i.hund == DIGIT_ZERO);
      below_rest = (count_i.tens != DIGIT_ZERO) || (count_i.units != DIGIT_ZERO);
      lo_flag_o = count_i.thou || !hund_zero;
      up_flag_o = count_i.thou && ((count_i.hund > UP_HUND) ||
                  ((count_i.hund == UP_HUND) && below_rest));
   end

endmodule : ars_limits

// ### rtl/ars_top.sv
// Automatic range selector with APB registers and settling delay
//
// How it works
// - The lower flag is low for a stored count under 100 and high otherwise.
// - The upper flag is high only when the stored count exceeds 1400.
// - State bits, low then high: 00 range 10, 10 range 100, 01 range 1000, 11 overload.
// - The range state changes only on the rising edge of the transfer pulse.
// - With the upper flag high and no overload, the range steps up by one.
// - Lower flag low: 100 to 10, 1000 and overload to 100; overload between limits to 1000.
// - The range holds between limits at 100 or 1000, below 100 at 10, above 1400 in overload.
// - Next-state inputs of both state bits are combinational and equal the target bits.
// - The range state decodes to one relay drive, or to the overload lamp instead.
// - Every range step starts a delay of about 100 ms, flagged on SETTLE_O; transfer edges during it still act.
// - In AC mode ranges 10, 100, 1000 drive relays A, B, C; in DC mode relays C, B, A.
`timescale 1ns/1ns
module ars_top
   import ars_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire ars_count_s COUNT_I,
   input wire logic TRANSFER_I,
   input wire ars_apb_req_s APB_I,
   output ars_apb_rsp_s APB_O,
   output logic LO_FLAG_O,
   output logic UP_FLAG_O,
   output logic RANGE_STATE_LOW_BIT_O,
   output logic RANGE_STATE_HIGH_BIT_O,
   output ars_drive_s DRIVE_O,
   output logic SETTLE_O,
   output logic IRQ_O
);

   localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYCLES);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   ars_state_s st_r;
   ars_state_s st_nxt;
   logic lo_flag;
   logic up_flag;
   logic xfer_edge;
   ars_range_e rng_target;
   logic d_low;
   logic d_high;
   logic step_up;
   logic step_down;
   logic apb_access;
   logic apb_hit;
   logic apb_wr;
   ars_status_s status;
   logic [31:0] rd_mux;
   ars_irq_s wr_irq;

   ars_limits u_limits (
      .count_i(COUNT_I),
      .lo_flag_o(lo_flag),
      .up_flag_o(up_flag)
   );

   // Sequencer pulse is synchronous; only its rising edge acts
   assign xfer_edge = CE_I && TRANSFER_I && !st_r.xfer_prev;

   // Target range; the impossible pair upper high with lower low is taken as a step up outside overload
   always_comb begin
      rng_target = st_r.rng;
      if (up_flag && (st_r.rng != RNG_OVL)) begin
         rng_target = ars_range_e'(st_r.rng + 2'h1);
      end else if (!lo_flag) begin
         unique case (st_r.rng)
            RNG_10: rng_target = RNG_10;
            RNG_100: rng_target = RNG_10;
            RNG_1000: rng_target = RNG_100;
            RNG_OVL: rng_target = RNG_100;
         endcase
      end else if ((st_r.rng == RNG_OVL) && !up_flag) begin
         rng_target = RNG_1000;
      end
   end

   // Gated inputs of the two state bits, equal to the bits to be taken
   assign d_low = rng_target[0];
   assign d_high = rng_target[1];

   assign step_up = xfer_edge && (rng_target > st_r.rng);
   assign step_down = xfer_edge && (rng_target < st_r.rng);

   // APB decode: the read word is captured in setup, so pready comes in the first access
   assign apb_hit = (APB_I.paddr == REG_CTRL) || (APB_I.paddr == REG_STATUS) ||
                    (APB_I.paddr == REG_IRQ_STS) || (APB_I.paddr == REG_IRQ_MSK);
   assign apb_access = APB_I.psel && APB_I.penable && st_r.rd_valid && CE_I;
   assign apb_wr = apb_access && APB_I.pwrite && apb_hit;
   assign wr_irq = ars_irq_s'(APB_I.pwdata[$bits(ars_irq_s)-1:0]);

   always_comb begin
      status = '0;
      status.range = st_r.rng;
      status.lo_flag = lo_flag;
      status.up_flag = up_flag;
      status.xfer = TRANSFER_I;
      status.settling = (st_r.settle_cnt != CNT_ZERO);
      rd_mux = DATA_ZERO;
      unique case (APB_I.paddr)
         REG_CTRL: rd_mux[CTRL_AC_BIT] = st_r.ac_mode;
         REG_STATUS: rd_mux = status;
         REG_IRQ_STS: rd_mux[$bits(ars_irq_s)-1:0] = st_r.irq_sts;
         REG_IRQ_MSK: rd_mux[$bits(ars_irq_s)-1:0] = st_r.irq_msk;
         default: rd_mux = DATA_ZERO;
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.xfer_prev = TRANSFER_I;
      if (xfer_edge) begin
         st_nxt.rng = ars_range_e'({d_high, d_low});
      end
      // Each step reloads the hold-off so back-to-back steps both settle
      if (step_up || step_down) begin
         st_nxt.settle_cnt = SETTLE_LOAD;
      end else if (st_r.settle_cnt != CNT_ZERO) begin
         st_nxt.settle_cnt = st_r.settle_cnt - CNT_ONE;
      end
      if (apb_access) begin
         st_nxt.rd_valid = 1'b0;
      end else if (APB_I.psel) begin
         st_nxt.rd_valid = 1'b1;
         st_nxt.prdata = rd_mux;
      end
      if (apb_wr && (APB_I.paddr == REG_CTRL)) begin
         st_nxt.ac_mode = APB_I.pwdata[CTRL_AC_BIT];
      end
      if (apb_wr && (APB_I.paddr == REG_IRQ_MSK)) begin
         st_nxt.irq_msk = wr_irq;
      end
      if (apb_wr && (APB_I.paddr == REG_IRQ_STS)) begin
         st_nxt.irq_sts = st_r.irq_sts & ~wr_irq;
      end
      // Set after clear, so an event in the clearing cycle survives
      if (step_up) begin
         st_nxt.irq_sts.up = 1'b1;
      end
      if (step_down) begin
         st_nxt.irq_sts.down = 1'b1;
      end
      if (step_up && (rng_target == RNG_OVL)) begin
         st_nxt.irq_sts.ovl = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         st_r <= '{rng: RNG_10, xfer_prev: 1'b0, ac_mode: CTRL_AC_RST,
                   irq_sts: IRQ_RST, irq_msk: IRQ_RST, settle_cnt: CNT_ZERO,
                   rd_valid: 1'b0, prdata: DATA_ZERO};
      end else if (CE_I) begin
         st_r <= st_nxt;
      end
   end

   // Relay decode; the overload lamp replaces any relay
   always_comb begin
      DRIVE_O = '0;
      unique case (st_r.rng)
         RNG_10: begin
            DRIVE_O.relay_a = st_r.ac_mode;
            DRIVE_O.relay_c = !st_r.ac_mode;
         end
         RNG_100: DRIVE_O.relay_b = 1'b1;
         RNG_1000: begin
            DRIVE_O.relay_c = st_r.ac_mode;
            DRIVE_O.relay_a = !st_r.ac_mode;
         end
         RNG_OVL: DRIVE_O.overload = 1'b1;
      endcase
   end

   assign APB_O.prdata = st_r.prdata;
   assign APB_O.pready = apb_access;
   assign APB_O.pslverr = apb_access && !apb_hit;
   assign LO_FLAG_O = lo_flag;
   assign UP_FLAG_O = up_flag;
   assign RANGE_STATE_LOW_BIT_O = st_r.rng[0];
   assign RANGE_STATE_HIGH_BIT_O = st_r.rng[1];
   assign SETTLE_O = (st_r.settle_cnt != CNT_ZERO);
   assign IRQ_O = |(st_r.irq_sts & st_r.irq_msk);

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   lower_flag_a: assert property (
      LO_FLAG_O == (COUNT_I.thou || (COUNT_I.hund != DIGIT_ZERO)))
      else $error("lower flag does not match count against 100");

   upper_flag_a: assert property (
      (COUNT_I.thou && (COUNT_I.hund > UP_HUND)) |-> UP_FLAG_O)
      else $error("upper flag low for a count above 1400");

   upper_low_a: assert property (
      (!COUNT_I.thou || (COUNT_I.hund < UP_HUND)) |-> !UP_FLAG_O)
      else $error("upper flag high for a count below 1400");

   edge_only_a: assert property (
      !xfer_edge |=> $stable(st_r.rng))
      else $error("range changed without a transfer edge");

   step_up_a: assert property (
      (xfer_edge && up_flag && (st_r.rng != RNG_OVL)) |=>
      (st_r.rng == ars_range_e'($past(st_r.rng) + 2'h1)))
      else $error("range did not step up above 1400");

   step_down_a: assert property (
      (xfer_edge && !lo_flag && !up_flag && (st_r.rng == RNG_1000)) |=>
      (st_r.rng == RNG_100) && RANGE_STATE_LOW_BIT_O && !RANGE_STATE_HIGH_BIT_O)
      else $error("range 1000 did not fall to 100 below 100");

   ovl_recover_a: assert property (
      (xfer_edge && lo_flag && !up_flag && (st_r.rng == RNG_OVL)) |=>
      (st_r.rng == RNG_1000))
      else $error("overload did not return to 1000 between limits");

   range_hold_a: assert property (
      (xfer_edge && lo_flag && !up_flag && (st_r.rng inside {RNG_100, RNG_1000})) |=>
      $stable(st_r.rng))
      else $error("range moved with count between limits");

   settle_run_a: assert property (
      (step_up || step_down) |=> SETTLE_O [*8])
      else $error("settling delay not held after a range step");

   relay_decode_a: assert property (
      $onehot(DRIVE_O) && (DRIVE_O.overload == (st_r.rng == RNG_OVL)))
      else $error("relay drive not a single output for the range");

   relay_map_a: assert property (
      (st_r.rng == RNG_10) |-> (DRIVE_O.relay_a == st_r.ac_mode) &&
      (DRIVE_O.relay_c == !st_r.ac_mode))
      else $error("range 10 relay does not follow the mode");

   // Range steps taken on a transfer edge
   step_top_a: assert property (
      (xfer_edge && up_flag && (st_r.rng == RNG_1000)) |=> DRIVE_O.overload)
      else $error("range 1000 did not step to overload above 1400");

   fall_ten_a: assert property (
      (xfer_edge && !lo_flag && (st_r.rng == RNG_100)) |=> (st_r.rng == RNG_10))
      else $error("range 100 did not fall to 10 below 100");

   ovl_fall_a: assert property (
      (xfer_edge && !lo_flag && (st_r.rng == RNG_OVL)) |=> (st_r.rng == RNG_100))
      else $error("overload did not fall to 100 below 100");

   ten_hold_a: assert property (
      (xfer_edge && !lo_flag && (st_r.rng == RNG_10)) |=> (st_r.rng == RNG_10))
      else $error("range 10 moved with count below 100");

   ovl_hold_a: assert property (
      (xfer_edge && up_flag && (st_r.rng == RNG_OVL)) |=> (st_r.rng == RNG_OVL))
      else $error("overload moved with count above 1400");

   next_state_a: assert property (
      xfer_edge |=>
      ({RANGE_STATE_HIGH_BIT_O, RANGE_STATE_LOW_BIT_O} == $past({d_high, d_low})))
      else $error("state bits differ from their gated inputs");

   step_once_a: assert property (
      xfer_edge |=> !xfer_edge)
      else $error("transfer edge seen twice without a low level");

   low_bit_a: assert property (
      RANGE_STATE_LOW_BIT_O == ((st_r.rng == RNG_100) || (st_r.rng == RNG_OVL)))
      else $error("low state bit does not match the range");

   high_bit_a: assert property (
      RANGE_STATE_HIGH_BIT_O == ((st_r.rng == RNG_1000) || (st_r.rng == RNG_OVL)))
      else $error("high state bit does not match the range");

   flag_order_a: assert property (
      UP_FLAG_O |-> LO_FLAG_O)
      else $error("upper flag high while lower flag low");

   relay_mid_a: assert property (
      (st_r.rng == RNG_100) |-> DRIVE_O.relay_b)
      else $error("range 100 does not drive relay B");

   relay_top_a: assert property (
      (st_r.rng == RNG_1000) |-> (DRIVE_O.relay_c == st_r.ac_mode) &&
      (DRIVE_O.relay_a == !st_r.ac_mode))
      else $error("range 1000 relay does not follow the mode");

   settle_start_a: assert property (
      (step_up || step_down) |=> (st_r.settle_cnt == SETTLE_LOAD))
      else $error("settling delay not reloaded by a range step");

   settle_idle_a: assert property (
      (!step_up && !step_down && !SETTLE_O) |=> !SETTLE_O)
      else $error("settling delay started without a range step");

   // Clock enable low must leave every bit of state alone
   ce_freeze_a: assert property (
      !CE_I |=> $stable(st_r))
      else $error("state moved while the clock enable was low");

   // Sticky event bits
   irq_up_a: assert property (
      step_up |=> st_r.irq_sts.up)
      else $error("step up did not set its status bit");

   irq_down_a: assert property (
      step_down |=> st_r.irq_sts.down)
      else $error("step down did not set its status bit");

   irq_ovl_a: assert property (
      (step_up && (st_r.rng == RNG_1000)) |=> st_r.irq_sts.ovl)
      else $error("entering overload did not set its status bit");

   irq_clear_a: assert property (
      (apb_wr && (APB_I.paddr == REG_IRQ_STS) && wr_irq.ovl && !step_up) |=>
      !st_r.irq_sts.ovl)
      else $error("overload status bit not cleared by writing a one");

   // Register bus handshake and writes
   ready_phase_a: assert property (
      APB_O.pready |-> (APB_I.psel && APB_I.penable && CE_I))
      else $error("ready outside an access phase");

   ready_first_a: assert property (
      (APB_I.psel && !APB_I.penable && CE_I) ##1 (APB_I.psel && APB_I.penable && CE_I) |->
      APB_O.pready)
      else $error("ready missing in the first access cycle");

   ctrl_write_a: assert property (
      (apb_wr && (APB_I.paddr == REG_CTRL)) |=>
      (st_r.ac_mode == $past(APB_I.pwdata[CTRL_AC_BIT])))
      else $error("mode bit not taken from a control write");

   mask_write_a: assert property (
      (apb_wr && (APB_I.paddr == REG_IRQ_MSK)) |=>
      (st_r.irq_msk == $past(wr_irq)))
      else $error("mask not taken from a mask write");

endmodule : ars_top

// ### tb/ars_seq_model.sv
// Measurement sequencer model: stored count and one transfer pulse per measuring cycle
`timescale 1ns/1ns
module ars_seq_model
   import ars_pkg::*;
(
   input wire logic clk_i,
   output ars_count_s count_o,
   output logic transfer_o
);
   initial begin
      count_o = '0;
      transfer_o = 1'b0;
   end
   // Count settles a cycle ahead of the pulse so the flags are steady at the edge
   task automatic measure(input int n, input int h);
      begin
         @(posedge clk_i);
         count_o.thou <= (n >= 1000);
         count_o.hund <= 4'((n / 100) % 10);
         count_o.tens <= 4'((n / 10) % 10);
         count_o.units <= 4'(n % 10);
         transfer_o <= 1'b0;
         @(posedge clk_i);
         transfer_o <= 1'b1;
         repeat (h) @(posedge clk_i);
         transfer_o <= 1'b0;
      end
   endtask : measure
endmodule : ars_seq_model

// ### tb/tb.sv
// Self-checking testbench for the automatic range selector
`timescale 1ns/1ns
module tb;
   import ars_pkg::*;
   localparam int unsigned SC = 16;
   logic clk, rst_n, xfer, lo, up, sl, sh, settle, irq, er, ac, ce;
   ars_apb_req_s req;
   ars_apb_rsp_s rsp;
   ars_count_s cnt;
   ars_drive_s drive;
   logic [31:0] rd;
   logic [1:0] rng;
   int errors, cmp_count, n;
   int seq[17] = '{0, 99, 1401, 100, 1500, 1400, 1999, 1401, 500, 99, 1999, 1999, 1000, 1401,
                   0, 0, 999};

   ars_top #(.SETTLE_CYCLES(SC)) ars_top_i (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .COUNT_I(cnt), .TRANSFER_I(xfer), .APB_I(req), .APB_O(rsp), .LO_FLAG_O(lo),
      .UP_FLAG_O(up), .RANGE_STATE_LOW_BIT_O(sl), .RANGE_STATE_HIGH_BIT_O(sh),
      .DRIVE_O(drive), .SETTLE_O(settle), .IRQ_O(irq));
   ars_seq_model ars_seq_model_i (.clk_i(clk), .count_o(cnt), .transfer_o(xfer));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task chk(input logic [31:0] g, input logic [31:0] e, input string m);
      begin
         cmp_count++;
         if (g !== e) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
         end
      end
   endtask : chk

   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int k;
      begin
         k = 0;
         @(posedge clk);
         req.paddr <= a;
         req.pwrite <= w;
         req.pwdata <= d;
         req.psel <= 1'b1;
         req.penable <= 1'b0;
         @(posedge clk);
         req.penable <= 1'b1;
         @(posedge clk);
         while (rsp.pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge clk);
         end
         if (k >= 50) begin
            errors++;
            $display("Error at %0t: no ready from the register bus", $time);
         end
         rd = rsp.prdata;
         er = rsp.pslverr;
         req.psel <= 1'b0;
         req.penable <= 1'b0;
         #1;
      end
   endtask : apb

   function automatic logic [1:0] nxt(input logic [1:0] r, input logic l, input logic u);
      if (u && r != 2'd3) return r + 2'd1;
      if (!l) return (r == 2'd3) ? 2'd1 : ((r == 2'd0) ? 2'd0 : r - 2'd1);
      if (r == 2'd3 && !u) return 2'd2;
      return r;
   endfunction : nxt

   function automatic ars_drive_s drv(input logic [1:0] r, input logic m);
      drv = '0;
      case (r)
         2'd0: if (m) drv.relay_a = 1'b1; else drv.relay_c = 1'b1;
         2'd1: drv.relay_b = 1'b1;
         2'd2: if (m) drv.relay_c = 1'b1; else drv.relay_a = 1'b1;
         default: drv.overload = 1'b1;
      endcase
   endfunction : drv

   task step(input int c, input int h);
      logic [1:0] nr;
      begin
         nr = nxt(rng, c >= 100, c > 1400);
         ars_seq_model_i.measure(c, h);
         #1;
         chk(32'(lo), 32'(c >= 100), "lower flag");
         chk(32'(up), 32'(c > 1400), "upper flag");
         chk(32'({sh, sl}), 32'(nr), "range");
         chk(32'(drive), 32'(drv(nr, ac)), "drive");
         if (nr != rng) chk(32'(settle), 32'd1, "settle on step");
         rng = nr;
      end
   endtask : step

   task report_and_stop;
      begin
         $display("Comparisons %0d, errors %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask : report_and_stop

   initial begin
      #2_000_000;
      errors++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      req = '0;
      ce = 1'b1;
      ac = 1'b0;
      rng = 2'd0;
      errors = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk(32'(drive), 32'(drv(2'd0, 1'b0)), "reset drive");
      chk(32'({irq, settle}), 32'd0, "reset irq settle");
      apb(REG_CTRL, 1'b0, DATA_ZERO);
      chk(rd, DATA_ZERO, "ctrl reset");
      foreach (seq[i]) step(seq[i], 1);
      apb(REG_CTRL, 1'b1, 32'h0000_0001);
      ac = 1'b1;
      chk(32'(drive), 32'(drv(rng, ac)), "ac drive");
      foreach (seq[i]) step(seq[i], 1);
      // Transfer held high must give a single step
      step(1500, 3);
      while (settle === 1'b1) @(posedge clk);
      #1;
      step(1500, 1);
      n = 0;
      while (settle === 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
         #1;
      end
      chk(32'(n), 32'(SC), "settle length");
      step(1000, 1);
      chk(32'(settle), 32'd0, "no settle on hold");
      // Clock enable low across a transfer pulse must leave the range alone
      @(posedge clk);
      ce <= 1'b0;
      ars_seq_model_i.measure(1500, 1);
      #1;
      chk(32'({sh, sl}), 32'(rng), "frozen range");
      @(posedge clk);
      ce <= 1'b1;
      apb(REG_IRQ_STS, 1'b1, 32'h0000_0007);
      step(1999, 1);
      apb(REG_IRQ_STS, 1'b0, DATA_ZERO);
      chk(rd, 32'h0000_0005, "irq status");
      chk(32'(irq), 32'd0, "irq masked");
      apb(REG_IRQ_MSK, 1'b1, 32'h0000_0004);
      chk(32'(irq), 32'd1, "irq raised");
      apb(REG_IRQ_STS, 1'b1, 32'h0000_0004);
      chk(32'(irq), 32'd0, "irq cleared");
      apb(REG_STATUS, 1'b0, DATA_ZERO);
      chk(32'(rd[3:0]), 32'h0000_000F, "status");
      chk(32'(er), 32'd0, "status response");
      apb(12'h010, 1'b0, DATA_ZERO);
      chk({rd[30:0], er}, 32'h0000_0001, "unmapped");
      // Reset in mid-run from overload in AC mode
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      #1;
      chk(32'({sh, sl, settle}), 32'd0, "mid-run reset state");
      chk(32'(drive), 32'(drv(2'd0, 1'b0)), "mid-run reset drive");
      @(posedge clk);
      rst_n <= 1'b1;
      apb(REG_CTRL, 1'b0, DATA_ZERO);
      chk(rd, DATA_ZERO, "ctrl after reset");
      report_and_stop();
   end
endmodule : tb
